/* File: ssaf_pkg.sv */
// Purpose: constants and carrier types of the stereo serial audio formatter
// Assumes: registers are 32-bit words on a classic Wishbone slave
// Notes:   Contract list follows
// Contract
// - LJ frame length exceeds twice word length
// - offset plus word length fits in frame
// - no slots: shared delay, each edge starts one
// - LJ data valid at bit-clock rising edges
// - slots: rise starts first, gap after LSB
// - LJ left MSB at delay+1 after rise
// - LJ swap: right after rise, left after fall
// - slot LJ: right MSB gap+1 after left LSB
// - slot swap: right first, left after gap
// - I2S MSB on second edge after word edge
// - I2S channel clocks at least word length
// - DSP: rise starts, left then right, no gap
// - DSP data valid at bit-clock falling edges
// - MSB first, 16/20/24/32-bit words
// - polarity bit inverts the data bit clock
// - after LSB: high impedance or driven zero
// - swap bit exchanges left/right order
`default_nettype none
package ssaf_pkg;
   // ************************************************
   // register map (byte addresses)
   // ************************************************
   localparam logic [7:0] SSAF_ADR_CTRL   = 8'h00;
   localparam logic [7:0] SSAF_ADR_OFFS   = 8'h04;
   localparam logic [7:0] SSAF_ADR_LEFT   = 8'h08;
   localparam logic [7:0] SSAF_ADR_RIGHT  = 8'h0c;
   localparam logic [7:0] SSAF_ADR_STATUS = 8'h10;
   // ************************************************
   // field positions
   // ************************************************
   localparam int SSAF_CTRL_SLOT   = 0;
   localparam int SSAF_CTRL_TRI    = 1;
   localparam int SSAF_CTRL_INV    = 3;
   localparam int SSAF_CTRL_SWAP   = 4;
   localparam int SSAF_CTRL_MODE   = 5;
   localparam int SSAF_CTRL_WLEN   = 8;
   localparam int SSAF_OFFS_FIRST  = 0;
   localparam int SSAF_OFFS_SECOND = 8;
   localparam int SSAF_ST_BUSY     = 0;
   localparam int SSAF_ST_DROP     = 1;
   localparam int SSAF_ST_CFGBAD   = 2;
   // ************************************************
   // encodings and reset values
   // ************************************************
   typedef enum logic [1:0] {SSAF_LJ, SSAF_I2S, SSAF_DSP, SSAF_RSVD} ssaf_mode_t;
   localparam logic [1:0] SSAF_WL16 = 2'h0;
   localparam logic [1:0] SSAF_WL20 = 2'h1;
   localparam logic [1:0] SSAF_WL24 = 2'h2;
   localparam logic [1:0] SSAF_WL32 = 2'h3;
   localparam logic [5:0] SSAF_BITS16 = 6'h10;
   localparam logic [5:0] SSAF_BITS20 = 6'h14;
   localparam logic [5:0] SSAF_BITS24 = 6'h18;
   localparam logic [5:0] SSAF_BITS32 = 6'h20;
   localparam logic [8:0] SSAF_I2S_LAG = 9'h001;
   localparam logic [31:0] SSAF_RST_WORD = 32'h0;
   typedef struct packed {
      logic [7:0] d2;
      logic [7:0] d1;
      logic [1:0] wlen;
      ssaf_mode_t mode;
      logic       swap;
      logic       inv;
      logic       triEn;
      logic       slot;
   } ssaf_cfg_t;
   localparam ssaf_cfg_t SSAF_RST_CFG = '{d2: 8'h0, d1: 8'h0, wlen: SSAF_WL16, mode: SSAF_LJ,
                                          swap: 1'b0, inv: 1'b0, triEn: 1'b0, slot: 1'b0};
endpackage : ssaf_pkg
`default_nettype wire

/* File: ssaf_formatter.sv */
// Purpose: two-channel serial audio transmit formatter with Wishbone registers
// Assumes: bit clock and word clock come from the far side; word clock is
//          synchronous to the bit clock
// Notes:   configuration is quasi-static; change it only while the link idles
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ssaf_formatter (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   input  wire logic        linkClk,
   input  wire logic        wordClk,
   output var  logic        dout,
   output var  logic        doutOe
);
   // ************************************************
   // register side (clk domain)
   // ************************************************
   ssaf_pkg::ssaf_cfg_t cfg;
   logic [31:0]         leftHold;
   logic [31:0]         xferL;
   logic [31:0]         xferR;
   logic                reqTog;
   logic                ackS1;
   logic                ackS2;
   logic                badS1;
   logic                badS2;
   logic                dropped;
   logic                busy;
   logic                wbReq;
   logic [31:0]         mask;
   logic [31:0]         cfgWord;
   logic [31:0]         offsWord;
   logic [31:0]         next_ctrl;
   logic [31:0]         next_offs;
   logic [31:0]         rdData;
   logic                ackTog;
   logic                cfgBad;

   assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign busy  = reqTog ^ ackS2;
   assign mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   always_comb begin
      cfgWord = 32'h0;
      cfgWord[ssaf_pkg::SSAF_CTRL_SLOT] = cfg.slot;
      cfgWord[ssaf_pkg::SSAF_CTRL_TRI]  = cfg.triEn;
      cfgWord[ssaf_pkg::SSAF_CTRL_INV]  = cfg.inv;
      cfgWord[ssaf_pkg::SSAF_CTRL_SWAP] = cfg.swap;
      cfgWord[ssaf_pkg::SSAF_CTRL_MODE +: 2] = cfg.mode;
      cfgWord[ssaf_pkg::SSAF_CTRL_WLEN +: 2] = cfg.wlen;
      offsWord = 32'h0;
      offsWord[ssaf_pkg::SSAF_OFFS_FIRST +: 8]  = cfg.d1;
      offsWord[ssaf_pkg::SSAF_OFFS_SECOND +: 8] = cfg.d2;
      next_ctrl = (cfgWord & ~mask) | (wb_dat_i & mask);
      next_offs = (offsWord & ~mask) | (wb_dat_i & mask);
   end

   always_comb begin
      rdData = 32'h0;
      case (wb_adr_i)
         ssaf_pkg::SSAF_ADR_CTRL:  rdData = cfgWord;
         ssaf_pkg::SSAF_ADR_OFFS:  rdData = offsWord;
         ssaf_pkg::SSAF_ADR_LEFT:  rdData = leftHold;
         ssaf_pkg::SSAF_ADR_RIGHT: rdData = xferR;
         ssaf_pkg::SSAF_ADR_STATUS: begin
            rdData[ssaf_pkg::SSAF_ST_BUSY]   = busy;
            rdData[ssaf_pkg::SSAF_ST_DROP]   = dropped;
            rdData[ssaf_pkg::SSAF_ST_CFGBAD] = badS2;
         end
         default: rdData = 32'h0;
      endcase
   end

   // one wait state: ack and read data are registered together
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= ssaf_pkg::SSAF_RST_WORD;
      end else begin
         wb_ack_o <= wbReq;
         wb_dat_o <= wbReq ? rdData : ssaf_pkg::SSAF_RST_WORD;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg <= ssaf_pkg::SSAF_RST_CFG;
      end else if (wbReq && wb_we_i && wb_adr_i == ssaf_pkg::SSAF_ADR_CTRL) begin
         cfg.slot  <= next_ctrl[ssaf_pkg::SSAF_CTRL_SLOT];
         cfg.triEn <= next_ctrl[ssaf_pkg::SSAF_CTRL_TRI];
         cfg.inv   <= next_ctrl[ssaf_pkg::SSAF_CTRL_INV];
         cfg.swap  <= next_ctrl[ssaf_pkg::SSAF_CTRL_SWAP];
         cfg.mode  <= ssaf_pkg::ssaf_mode_t'(next_ctrl[ssaf_pkg::SSAF_CTRL_MODE +: 2]);
         cfg.wlen  <= next_ctrl[ssaf_pkg::SSAF_CTRL_WLEN +: 2];
      end else if (wbReq && wb_we_i && wb_adr_i == ssaf_pkg::SSAF_ADR_OFFS) begin
         cfg.d1 <= next_offs[ssaf_pkg::SSAF_OFFS_FIRST +: 8];
         cfg.d2 <= next_offs[ssaf_pkg::SSAF_OFFS_SECOND +: 8];
      end
   end

   // a pair is handed over only while no earlier pair is in flight,
   // so xferL/xferR stay still while the link side copies them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         leftHold <= ssaf_pkg::SSAF_RST_WORD;
         xferL    <= ssaf_pkg::SSAF_RST_WORD;
         xferR    <= ssaf_pkg::SSAF_RST_WORD;
         reqTog   <= 1'b0;
         dropped  <= 1'b0;
      end else begin
         if (wbReq && wb_we_i && wb_adr_i == ssaf_pkg::SSAF_ADR_LEFT)
            leftHold <= (leftHold & ~mask) | (wb_dat_i & mask);
         if (wbReq && wb_we_i && wb_adr_i == ssaf_pkg::SSAF_ADR_RIGHT && !busy) begin
            xferL  <= leftHold;
            xferR  <= (xferR & ~mask) | (wb_dat_i & mask);
            reqTog <= ~reqTog;
         end
         // set wins over a clear in the same cycle
         if (wbReq && wb_we_i && wb_adr_i == ssaf_pkg::SSAF_ADR_RIGHT && busy)
            dropped <= 1'b1;
         else if (wbReq && wb_we_i && wb_adr_i == ssaf_pkg::SSAF_ADR_STATUS &&
                  wb_sel_i[0] && wb_dat_i[ssaf_pkg::SSAF_ST_DROP])
            dropped <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ackS1 <= 1'b0;
         ackS2 <= 1'b0;
         badS1 <= 1'b0;
         badS2 <= 1'b0;
      end else begin
         ackS1 <= ackTog;
         ackS2 <= ackS1;
         badS1 <= cfgBad;
         badS2 <= badS1;
      end
   end

   // ************************************************
   // link side (linkClk domain)
   // ************************************************
   typedef enum {SSAF_IDLE, SSAF_WAIT, SSAF_SEND} ssaf_state_t;
   ssaf_state_t         state;
   ssaf_pkg::ssaf_cfg_t cfgS1;
   ssaf_pkg::ssaf_cfg_t cfgL;
   logic        rstQ1;
   logic        linkRst;
   logic        reqS1;
   logic        reqS2;
   logic        wS;
   logic        wP;
   logic        wQ;
   logic        rise;
   logic        fall;
   logic [31:0] frameL;
   logic [31:0] frameR;
   logic [9:0]  frameCnt;
   logic [9:0]  frameLen;
   logic [5:0]  wl;
   logic        beginChan;
   logic        beginSel;
   logic [8:0]  beginDelay;
   logic        firstOfPair;
   logic        endChan;
   logic        emitNow;
   logic        emitSel;
   logic [31:0] emitWord;
   logic        secondPend;
   logic        pairSel;
   logic        pendSel;
   logic [8:0]  cnt;
   logic [5:0]  rem;
   logic [31:0] sh;
   logic        outPos;
   logic        oePos;
   logic        outNeg;
   logic        oeNeg;
   logic        edgeSel;

   always_ff @(posedge linkClk or posedge rst) begin
      if (rst) begin
         rstQ1   <= 1'b1;
         linkRst <= 1'b1;
      end else begin
         rstQ1   <= 1'b0;
         linkRst <= rstQ1;
      end
   end

   // configuration crosses as levels; it must be stable while frames run
   always_ff @(posedge linkClk or posedge linkRst) begin
      if (linkRst) begin
         cfgS1 <= ssaf_pkg::SSAF_RST_CFG;
         cfgL  <= ssaf_pkg::SSAF_RST_CFG;
         reqS1 <= 1'b0;
         reqS2 <= 1'b0;
         wS    <= 1'b0;
         wP    <= 1'b0;
         wQ    <= 1'b0;
      end else begin
         cfgS1 <= cfg;
         cfgL  <= cfgS1;
         reqS1 <= reqTog;
         reqS2 <= reqS1;
         wS    <= wordClk;
         wP    <= wS;
         wQ    <= wP;
      end
   end

   // edges are taken past the two-flop synchroniser; the first flop may be metastable
   assign rise = wP & ~wQ;
   assign fall = ~wP & wQ;

   always_comb begin
      case (cfgL.wlen)
         ssaf_pkg::SSAF_WL16: wl = ssaf_pkg::SSAF_BITS16;
         ssaf_pkg::SSAF_WL20: wl = ssaf_pkg::SSAF_BITS20;
         ssaf_pkg::SSAF_WL24: wl = ssaf_pkg::SSAF_BITS24;
         default:             wl = ssaf_pkg::SSAF_BITS32;
      endcase
   end

   // a new pair is taken at the frame start only; a first word sent with zero start delay still comes from the previous pair
   always_ff @(posedge linkClk or posedge linkRst) begin
      if (linkRst) begin
         frameL   <= ssaf_pkg::SSAF_RST_WORD;
         frameR   <= ssaf_pkg::SSAF_RST_WORD;
         ackTog   <= 1'b0;
         frameCnt <= 10'h0;
         frameLen <= 10'h0;
         cfgBad   <= 1'b0;
      end else begin
         if (rise && reqS2 != ackTog) begin
            frameL <= xferL;
            frameR <= xferR;
            ackTog <= reqS2;
         end
         if (rise) begin
            frameCnt <= 10'h1;
            frameLen <= frameCnt;
         end else if (frameCnt != 10'h3ff) begin
            frameCnt <= frameCnt + 10'h1;
         end
         if (cfgL.mode == ssaf_pkg::SSAF_I2S)
            cfgBad <= ({1'b0, frameLen[9:1]} < {4'h0, wl}) ||
                      ({2'h0, cfgL.d1} + {4'h0, wl} > frameLen);
         else
            cfgBad <= (frameLen <= {3'h0, wl, 1'b0}) ||
                      ({2'h0, cfgL.d1} + {4'h0, wl} > frameLen);
      end
   end

   // channel 0 is left, 1 is right
   always_comb begin
      beginChan   = 1'b0;
      beginSel    = 1'b0;
      beginDelay  = 9'h0;
      firstOfPair = 1'b0;
      endChan     = (state == SSAF_SEND) && (rem == 6'h0);
      if (endChan && secondPend) begin
         beginChan  = 1'b1;
         beginSel   = pairSel;
         beginDelay = cfgL.slot ? {1'b0, cfgL.d2} : 9'h0;
      end
      if (cfgL.slot || cfgL.mode == ssaf_pkg::SSAF_DSP) begin
         // falling word-clock edge is not used here
         if (rise) begin
            beginChan   = 1'b1;
            beginSel    = cfgL.swap;
            beginDelay  = {1'b0, cfgL.d1} +
                          ((cfgL.mode == ssaf_pkg::SSAF_I2S) ? ssaf_pkg::SSAF_I2S_LAG : 9'h0);
            firstOfPair = 1'b1;
         end
      end else if (rise || fall) begin
         beginChan = 1'b1;
         if (cfgL.mode == ssaf_pkg::SSAF_I2S) begin
            beginSel   = rise ? ~cfgL.swap : cfgL.swap;
            beginDelay = {1'b0, cfgL.d1} + ssaf_pkg::SSAF_I2S_LAG;
         end else begin
            beginSel   = rise ? cfgL.swap : ~cfgL.swap;
            beginDelay = {1'b0, cfgL.d1};
         end
      end
      emitNow  = beginChan ? (beginDelay == 9'h0) : (state == SSAF_WAIT && cnt == 9'h0);
      emitSel  = beginChan ? beginSel : pendSel;
      emitWord = (emitSel ? frameR : frameL) << (6'h20 - wl);
   end

   always_ff @(posedge linkClk or posedge linkRst) begin
      if (linkRst) begin
         state      <= SSAF_IDLE;
         cnt        <= 9'h0;
         rem        <= 6'h0;
         sh         <= ssaf_pkg::SSAF_RST_WORD;
         outPos     <= 1'b0;
         oePos      <= 1'b0;
         pendSel    <= 1'b0;
         secondPend <= 1'b0;
         pairSel    <= 1'b0;
      end else begin
         if (beginChan) begin
            secondPend <= firstOfPair;
            pairSel    <= ~beginSel;
         end
         if (emitNow) begin
            state  <= SSAF_SEND;
            sh     <= emitWord << 1;
            outPos <= emitWord[31];
            oePos  <= 1'b1;
            rem    <= wl - 6'h1;
         end else if (beginChan) begin
            state   <= SSAF_WAIT;
            cnt     <= beginDelay - 9'h1;
            pendSel <= beginSel;
            outPos  <= 1'b0;
            oePos   <= ~cfgL.triEn;
         end else begin
            case (state)
               SSAF_WAIT: begin
                  cnt <= cnt - 9'h1;
               end
               SSAF_SEND: begin
                  if (rem != 6'h0) begin
                     sh     <= sh << 1;
                     outPos <= sh[31];
                     rem    <= rem - 6'h1;
                  end else begin
                     state  <= SSAF_IDLE;
                     outPos <= 1'b0;
                     oePos  <= ~cfgL.triEn;
                  end
               end
               SSAF_IDLE: begin
                  outPos <= 1'b0;
                  oePos  <= ~cfgL.triEn;
               end
               default: state <= SSAF_IDLE;
            endcase
         end
      end
   end

   // ************************************************
   // output stage
   // ************************************************
   // half-cycle copy so data can change on either bit-clock edge
   always_ff @(negedge linkClk or posedge linkRst) begin
      if (linkRst) begin
         outNeg <= 1'b0;
         oeNeg  <= 1'b0;
      end else begin
         outNeg <= outPos;
         oeNeg  <= oePos;
      end
   end

   // polarity swaps which edge the data is valid at; the final pick is a
   // two-input select because no single edge serves every framing
   assign edgeSel = (cfgL.mode == ssaf_pkg::SSAF_DSP) ^ cfgL.inv;
   assign dout    = edgeSel ? outPos : outNeg;
   assign doutOe  = edgeSel ? oePos : oeNeg;

   // ************************************************
   // checks
   // ************************************************
   a_tri_after_lsb: assert property (@(posedge linkClk) disable iff (linkRst)
      (endChan && !beginChan && cfgL.triEn) |=> (!oePos && state == SSAF_IDLE))
      else $error("output not released after last bit");
   a_zero_fill: assert property (@(posedge linkClk) disable iff (linkRst)
      (endChan && !beginChan && !cfgL.triEn) |=> (oePos && !outPos))
      else $error("unused bit clock not driven low");
   a_msb_load: assert property (@(posedge linkClk) disable iff (linkRst)
      emitNow |=> (state == SSAF_SEND && rem == $past(wl) - 6'h1 && outPos == $past(emitWord[31])))
      else $error("word does not start with its msb");
   a_start_delay: assert property (@(posedge linkClk) disable iff (linkRst)
      (beginChan && beginDelay != 9'h0) |=> (state == SSAF_WAIT && cnt == $past(beginDelay) - 9'h1))
      else $error("start delay not loaded");
   a_lj_order: assert property (@(posedge linkClk) disable iff (linkRst)
      (cfgL.mode == ssaf_pkg::SSAF_LJ && !cfgL.slot && rise) |-> (beginSel == cfgL.swap))
      else $error("wrong channel on word clock rise");
   a_slot_fall: assert property (@(posedge linkClk) disable iff (linkRst)
      (cfgL.slot && fall && !(endChan && secondPend)) |-> !beginChan)
      else $error("falling word clock used in slot mode");
   a_i2s_lag: assert property (@(posedge linkClk) disable iff (linkRst)
      (cfgL.mode == ssaf_pkg::SSAF_I2S && !cfgL.slot && fall) |->
         (beginDelay == {1'b0, cfgL.d1} + 9'h1 && beginSel == cfgL.swap))
      else $error("i2s start not one clock late");
   a_dsp_edge: assert property (@(posedge linkClk) disable iff (linkRst)
      (cfgL.mode == ssaf_pkg::SSAF_DSP && !cfgL.inv) |-> (dout == outPos))
      else $error("dsp data not launched on rising edge");
   a_dsp_gapless: assert property (@(posedge linkClk) disable iff (linkRst)
      (cfgL.mode == ssaf_pkg::SSAF_DSP && !cfgL.slot && endChan && secondPend && !rise) |=>
         (state == SSAF_SEND && oePos))
      else $error("dsp second channel not back to back");
   a_slot_gap: assert property (@(posedge linkClk) disable iff (linkRst)
      (cfgL.slot && endChan && secondPend && !rise) |-> (beginDelay == {1'b0, cfgL.d2}))
      else $error("second slot gap not applied");
   a_ack_pulse: assert property (@(posedge clk) disable iff (rst)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
endmodule : ssaf_formatter
`default_nettype wire

/* File: ssaf_link_model.sv */
// Purpose: far-side model of the serial audio bus for the formatter bench
// Assumes: 64 bit clocks per frame, square word clock, both made here
// Notes:   records dout on both bit-clock edges, one frame snapshot at a time
`timescale 1ns/1ps
`default_nettype none
module ssaf_link_model (
   input  wire logic        run,
   input  wire logic        dout,
   input  wire logic        doutOe,
   output var  logic        linkClk,
   output var  logic        wordClk,
   output var  logic [63:0] snapPos,
   output var  logic [63:0] snapNeg,
   output var  logic [63:0] snapOe,
   output var  int          frames
);
   // ********************************
   // clocks and capture
   // ********************************
   logic [5:0]  cnt;
   logic [63:0] posD;
   logic [63:0] posOe;
   logic [63:0] negD;
   initial begin
      linkClk = 1'b0;
      wordClk = 1'b0;
      cnt = 6'h00;
      frames = 0;
   end
   // bit clock parks low so a stopped link never leaves a half pulse
   always begin
      #32;
      if (run || linkClk) linkClk = ~linkClk;
   end
   // 64-clock frame stays above twice any word length used here
   always @(posedge linkClk) begin
      // a released line reads as the inverse so stale data cannot pass
      posD[cnt] = doutOe ? dout : ~dout;
      posOe[cnt] = doutOe;
      if (cnt == 6'h3f) begin
         snapPos <= posD;
         snapNeg <= negD;
         snapOe <= posOe;
         frames <= frames + 1;
      end
      wordClk <= (cnt == 6'h3f) || (cnt < 6'h1f);
      cnt <= cnt + 6'h01;
   end
   always @(negedge linkClk) begin
      negD[cnt] = doutOe ? dout : ~dout;
   end
endmodule : ssaf_link_model
`default_nettype wire

/* File: tb.sv */
// Purpose: self-checking bench of the serial audio formatter
// Assumes: link model gives a 64-clock frame; pin-to-engine lag of three clocks
// Notes:   each frame row is a packed configuration value
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ********************************
   // signals and instances
   // ********************************
   localparam logic [31:0] LW = 32'hc3a59e17;
   localparam logic [31:0] RW = 32'h5a3ce1f4;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic        run = 1'b1;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdOut, rdat;
   logic        ack, linkClk, wordClk, dout, doutOe;
   logic [63:0] sPos, sNeg, sOe;
   int          frames, mismatches, total_checks;
   ssaf_formatter ssaf_formatter_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdOut), .wb_ack_o(ack),
      .linkClk(linkClk), .wordClk(wordClk), .dout(dout), .doutOe(doutOe));
   ssaf_link_model ssaf_link_model_i (.run(run), .dout(dout), .doutOe(doutOe), .linkClk(linkClk),
      .wordClk(wordClk), .snapPos(sPos), .snapNeg(sNeg), .snapOe(sOe), .frames(frames));
   always #20 clk = ~clk;
   // ********************************
   // shared tasks
   // ********************************
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   task automatic timedOut();
      mismatches++;
      $display("Error wait expected done seen timeout");
      summarize();
   endtask : timedOut
   // one edge idles first so a released strobe always stays low a cycle
   task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rdat = rdOut;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) timedOut();
   endtask : wbXfer
   // ********************************
   // scenarios
   // ********************************
   task automatic regReset();
      wbXfer(1'b0, ssaf_pkg::SSAF_ADR_CTRL, 32'h0);
      check("ctrl reset", rdat, ssaf_pkg::SSAF_RST_WORD);
      wbXfer(1'b1, 8'h1c, 32'hffffffff);
      wbXfer(1'b0, 8'h1c, 32'h0);
      check("unmapped read", rdat, 32'h0);
   endtask : regReset
   // link stopped keeps the pair in flight, so the second right word must drop
   task automatic dropCheck();
      run <= 1'b0;
      repeat (4) @(posedge clk);
      wbXfer(1'b1, ssaf_pkg::SSAF_ADR_LEFT, LW);
      wbXfer(1'b1, ssaf_pkg::SSAF_ADR_RIGHT, RW);
      wbXfer(1'b1, ssaf_pkg::SSAF_ADR_RIGHT, 32'h3);
      wbXfer(1'b0, ssaf_pkg::SSAF_ADR_STATUS, 32'h0);
      check("busy and drop", rdat & 32'h3, 32'h3);
      wbXfer(1'b0, ssaf_pkg::SSAF_ADR_RIGHT, 32'h0);
      check("right kept", rdat, RW);
      wbXfer(1'b1, ssaf_pkg::SSAF_ADR_STATUS, 32'h2);
      wbXfer(1'b0, ssaf_pkg::SSAF_ADR_STATUS, 32'h0);
      check("drop cleared", rdat & 32'h3, 32'h1);
   endtask : dropCheck
   task automatic frame(input ssaf_pkg::ssaf_cfg_t v);
      logic [31:0] g1, g2, m, l, r;
      logic [63:0] a;
      logic        i2s, dsp, lf, neg;
      int          nb, f, s, k, n;
      nb = (v.wlen == ssaf_pkg::SSAF_WL32) ? 32 : 16 + 4 * v.wlen;
      i2s = v.mode == ssaf_pkg::SSAF_I2S;
      dsp = v.mode == ssaf_pkg::SSAF_DSP;
      lf = i2s ? v.swap : !v.swap;
      neg = dsp != v.inv;
      f = 3 + v.d1 + i2s;
      s = (v.slot || dsp) ? f + nb + (v.slot ? v.d2 : 0) : f + 32;
      m = 32'((64'h1 << nb) - 64'h1);
      l = LW & m;
      r = RW & m;
      run <= 1'b0;
      repeat (4) @(posedge clk);
      wbXfer(1'b1, ssaf_pkg::SSAF_ADR_CTRL, {22'h0, v.wlen, 1'b0, v.mode, v.swap, v.inv, 1'b0, v.triEn, v.slot});
      wbXfer(1'b1, ssaf_pkg::SSAF_ADR_OFFS, {16'h0, v.d2, v.d1});
      wbXfer(1'b1, ssaf_pkg::SSAF_ADR_LEFT, LW);
      wbXfer(1'b1, ssaf_pkg::SSAF_ADR_RIGHT, RW);
      run <= 1'b1;
      k = frames;
      n = 0;
      while (frames < k + 3 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000) timedOut();
      a = neg ? sNeg : sPos;
      g1 = 32'h0;
      g2 = 32'h0;
      for (k = 0; k < nb; k++) begin
         g1[nb - 1 - k] = a[f + k];
         g2[nb - 1 - k] = a[s + k];
      end
      check("first word", g1, lf ? l : r);
      check("second word", g2, lf ? r : l);
      if (!neg) begin
         check("enable at msb", {31'h0, sOe[f]}, 32'h1);
         check("enable after lsb", {31'h0, sOe[f + nb]}, {31'h0, !v.triEn});
         if (!v.triEn) check("zero after lsb", {31'h0, sPos[f + nb]}, 32'h0);
      end
      wbXfer(1'b0, ssaf_pkg::SSAF_ADR_STATUS, 32'h0);
      check("config ok", {31'h0, rdat[ssaf_pkg::SSAF_ST_CFGBAD]}, 32'h0);
   endtask : frame
   // ********************************
   // main sequence
   // ********************************
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      regReset();
      dropCheck();
      frame(24'h000000);
      frame(24'h000108);
      frame(24'h010001);
      frame(24'h010009);
      frame(24'h000010);
      frame(24'h000210);
      frame(24'h000120);
      frame(24'h030021);
      frame(24'h000004);
      frame(24'h000002);
      frame(24'h000040);
      frame(24'h0000a0);
      summarize();
   end
endmodule : tb
`default_nettype wire
